// ### gear_scaler.sv
// Electronic gear pulse scaler top: Wishbone registers, ratio selection,
// command and output-pulse scaling, alarms and interrupt.
// Assumes command steps synchronous to clock, one at most per cycle.
// Contract
// - Nonzero pulses-per-rev sets per-revolution scaling
// - Zero ppr and numerator: resolution over denominator
// - Zero ppr, nonzero numerator: numerator over denominator
// - Internal counts equal pulses times ratio
// - Full-closed ignores ppr; zero numerator means 1/1
// - Full-closed nonzero numerator: numerator over denominator
// - Unprocessable scaled pulses raise multiplication alarm
// - Ratio change in full-closed raises hybrid alarm
// - Output ppr 0..2097152, reset 2500
// - Nonzero output denominator: fractional output division
// - Starred settings load only at power-on
// - Gear terms active when ppr zero; defaults
// - Zero output denominator: output ppr direct
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gear_scaler (
    input wire logic clock, // System clock 10 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state except the reset release stages
    input wire logic [31:0] wb_adr_i, // Wishbone address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic wb_we_i, // Wishbone write
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire gear_pkg::pulse_t cmd_in, // Command pulse step and direction
    output gear_pkg::pulse_t pos_cmd, // Scaled position command count
    input wire gear_pkg::pulse_t enc_in, // Encoder count step (x4 counts)
    output gear_pkg::pulse_t enc_out, // Reproduced output pulse step
    output logic multiplication_error_alarm, // Sticky alarm level
    output logic hybrid_deviation_alarm, // Sticky alarm level
    output logic irq // Interrupt level
);
    // ==================== Reset release
    logic [1:0] rst_sync_ff;
    logic rst_b_sync;

    // Two-stage release of reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_b_sync = rst_sync_ff[1];

    // ==================== Register bus
    logic [31:0] command_pulses_per_rev_ff;
    logic [31:0] gear_numerator_ff;
    logic [31:0] gear_denominator_ff;
    logic [31:0] output_pulses_per_rev_ff;
    logic [31:0] output_division_denominator_ff;
    logic [31:0] act_ppr_ff;
    logic [31:0] act_out_ppr_ff;
    logic [31:0] act_out_den_ff;
    logic full_closed_ff;
    logic [gear_pkg::ST_W-1:0] status_ff;
    logic [gear_pkg::ST_W-1:0] mask_ff;
    logic [31:0] pos_cnt_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic req;
    logic wr;
    logic [7:0] adr;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic power_on;
    logic [gear_pkg::ST_W-1:0] st_set;
    logic [gear_pkg::ST_W-1:0] st_clr;

    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i;
    assign adr = wb_adr_i[7:0];
    assign power_on = wr && adr == gear_pkg::A_CTRL && wb_sel_i[0]
        && wb_dat_i[gear_pkg::CTRL_POWER_ON];

    // Byte-lane write mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // Apply byte lanes to a register value
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (wb_dat_i & wmask);
    endfunction

    // Upper-bound clamp of a written value
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] mx);
        clamp = (v > mx) ? mx : v;
    endfunction

    // One-cycle acknowledge, dropped the next cycle
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            ack_ff <= 1'b0;
        end else if (ce) begin
            ack_ff <= req;
        end
    end

    // Settings writes, clamped to their ranges
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            command_pulses_per_rev_ff <= gear_pkg::RST_PPR;
            gear_numerator_ff <= gear_pkg::RST_NUM;
            gear_denominator_ff <= gear_pkg::RST_DEN;
            output_pulses_per_rev_ff <= gear_pkg::RST_OUT_PPR;
            output_division_denominator_ff <= gear_pkg::RST_OUT_DEN;
            full_closed_ff <= 1'b0;
            mask_ff <= '0;
        end else if (ce && wr) begin
            unique case (adr)
                gear_pkg::A_PPR: begin
                    command_pulses_per_rev_ff <= clamp(merge(command_pulses_per_rev_ff),
                        gear_pkg::PPR_MAX);
                end
                gear_pkg::A_NUM: begin
                    gear_numerator_ff <= clamp(merge(gear_numerator_ff), gear_pkg::GEAR_MAX);
                end
                gear_pkg::A_DEN: begin
                    gear_denominator_ff <= (merge(gear_denominator_ff) == '0) ? gear_pkg::ONE
                        : clamp(merge(gear_denominator_ff), gear_pkg::GEAR_MAX);
                end
                gear_pkg::A_OUT_PPR: begin
                    output_pulses_per_rev_ff <= clamp(merge(output_pulses_per_rev_ff),
                        gear_pkg::OUT_PPR_MAX);
                end
                gear_pkg::A_OUT_DEN: begin
                    output_division_denominator_ff <= clamp(
                        merge(output_division_denominator_ff), gear_pkg::OUT_DEN_MAX);
                end
                gear_pkg::A_CTRL: begin
                    if (wb_sel_i[0]) begin
                        full_closed_ff <= wb_dat_i[gear_pkg::CTRL_FULL_CLOSED];
                    end
                end
                gear_pkg::A_MASK: begin
                    if (wb_sel_i[0]) begin
                        mask_ff <= wb_dat_i[gear_pkg::ST_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Power-on copies of starred settings
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            act_ppr_ff <= gear_pkg::RST_PPR;
            act_out_ppr_ff <= gear_pkg::RST_OUT_PPR;
            act_out_den_ff <= gear_pkg::RST_OUT_DEN;
        end else if (ce && power_on) begin
            act_ppr_ff <= command_pulses_per_rev_ff;
            act_out_ppr_ff <= output_pulses_per_rev_ff;
            act_out_den_ff <= output_division_denominator_ff;
        end
    end

    // Read data register, unmapped reads zero
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            rdata_ff <= '0;
        end else if (ce && req) begin
            unique case (adr)
                gear_pkg::A_PPR: rdata_ff <= command_pulses_per_rev_ff;
                gear_pkg::A_NUM: rdata_ff <= gear_numerator_ff;
                gear_pkg::A_DEN: rdata_ff <= gear_denominator_ff;
                gear_pkg::A_OUT_PPR: rdata_ff <= output_pulses_per_rev_ff;
                gear_pkg::A_OUT_DEN: rdata_ff <= output_division_denominator_ff;
                gear_pkg::A_CTRL: rdata_ff <= {31'h0000_0000, full_closed_ff};
                gear_pkg::A_STATUS: rdata_ff <= {30'h0000_0000, status_ff};
                gear_pkg::A_MASK: rdata_ff <= {30'h0000_0000, mask_ff};
                gear_pkg::A_ACTIVE_PPR: rdata_ff <= act_ppr_ff;
                gear_pkg::A_POS_CNT: rdata_ff <= pos_cnt_ff;
                default: rdata_ff <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // ==================== Ratio selection
    gear_pkg::ratio_t cmd_ratio;
    gear_pkg::ratio_t out_ratio;
    gear_pkg::ratio_t prev_ratio_ff;
    logic prev_fc_ff;

    // Command gear ratio by mode and settings
    always_comb begin
        if (full_closed_ff) begin
            if (gear_numerator_ff == '0) begin
                cmd_ratio.num = gear_pkg::ONE;
                cmd_ratio.den = gear_pkg::ONE;
            end else begin
                cmd_ratio.num = gear_numerator_ff;
                cmd_ratio.den = gear_denominator_ff;
            end
        end else if (act_ppr_ff != '0) begin
            cmd_ratio.num = gear_pkg::ENC_RES;
            cmd_ratio.den = act_ppr_ff;
        end else if (gear_numerator_ff == '0) begin
            cmd_ratio.num = gear_pkg::ENC_RES;
            cmd_ratio.den = gear_denominator_ff;
        end else begin
            cmd_ratio.num = gear_numerator_ff;
            cmd_ratio.den = gear_denominator_ff;
        end
    end

    // Output division: counts in are x4 encoder counts
    always_comb begin
        if (act_out_den_ff != '0) begin
            out_ratio.num = act_out_ppr_ff;
            out_ratio.den = act_out_den_ff;
        end else begin
            out_ratio.num = act_out_ppr_ff * gear_pkg::QUAD_MULT;
            out_ratio.den = gear_pkg::ENC_RES;
        end
    end

    // ==================== Scalers
    logic cmd_overrun;
    logic out_zero;

    frac_scaler u_cmd (
        .clock(clock),
        .rst_b_sync(rst_b_sync),
        .ce(ce),
        .ratio(cmd_ratio),
        .pin(cmd_in),
        .busy(),
        .overrun(cmd_overrun),
        .pout(pos_cmd)
    );

    assign out_zero = out_ratio.num == '0;

    frac_scaler u_out (
        .clock(clock),
        .rst_b_sync(rst_b_sync),
        .ce(ce),
        .ratio(out_ratio),
        .pin('{step: enc_in.step && !out_zero, dir: enc_in.dir}),
        .busy(),
        .overrun(),
        .pout(enc_out)
    );

    // Signed internal position count
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            pos_cnt_ff <= '0;
        end else if (ce && pos_cmd.step) begin
            pos_cnt_ff <= pos_cmd.dir ? pos_cnt_ff - gear_pkg::ONE
                : pos_cnt_ff + gear_pkg::ONE;
        end
    end

    // ==================== Alarms and interrupt
    // Ratio history for change detection in full-closed
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            prev_ratio_ff <= '0;
            prev_fc_ff <= 1'b0;
        end else if (ce) begin
            prev_ratio_ff <= cmd_ratio;
            prev_fc_ff <= full_closed_ff;
        end
    end

    assign st_set[gear_pkg::ST_MULT_ERR] = cmd_overrun;
    assign st_set[gear_pkg::ST_HYB_DEV] = full_closed_ff
        && prev_fc_ff && cmd_ratio != prev_ratio_ff;
    assign st_clr = (wr && adr == gear_pkg::A_STATUS && wb_sel_i[0])
        ? wb_dat_i[gear_pkg::ST_W-1:0] : '0;

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            status_ff <= '0;
        end else if (ce) begin
            status_ff <= (status_ff & ~st_clr) | st_set;
        end
    end

    assign multiplication_error_alarm = status_ff[gear_pkg::ST_MULT_ERR];
    assign hybrid_deviation_alarm = status_ff[gear_pkg::ST_HYB_DEV];
    assign irq = |(status_ff & mask_ff);
endmodule
`default_nettype wire

// ### gear_pkg.sv
// Package for the electronic gear pulse scaler: constants, register map, types.
// Assumes a 10 MHz clock and a classic Wishbone register bus with 32-bit data.
package gear_pkg;

    // ==================== Clock and resolution
    localparam int CLOCK_HZ = 10000000;
    localparam logic [31:0] ENC_RES = 32'h0080_0000; // Counts per revolution
    localparam logic [31:0] QUAD_MULT = 32'h0000_0004;
    localparam logic [31:0] PPR_MAX = 32'h0080_0000;
    localparam logic [31:0] GEAR_MAX = 32'h4000_0000;
    localparam logic [31:0] OUT_PPR_MAX = 32'h0020_0000;
    localparam logic [31:0] OUT_DEN_MAX = 32'h0080_0000;
    localparam logic [31:0] ONE = 32'h0000_0001;

    // ==================== Reset values
    localparam logic [31:0] RST_PPR = 32'h0000_2710; // 10000
    localparam logic [31:0] RST_NUM = 32'h0000_0000;
    localparam logic [31:0] RST_DEN = 32'h0000_2710; // 10000
    localparam logic [31:0] RST_OUT_PPR = 32'h0000_09c4; // 2500
    localparam logic [31:0] RST_OUT_DEN = 32'h0000_0000;

    // ==================== Register byte addresses
    localparam logic [7:0] A_PPR = 8'h00;
    localparam logic [7:0] A_NUM = 8'h04;
    localparam logic [7:0] A_DEN = 8'h08;
    localparam logic [7:0] A_OUT_PPR = 8'h0c;
    localparam logic [7:0] A_OUT_DEN = 8'h10;
    localparam logic [7:0] A_CTRL = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_MASK = 8'h1c;
    localparam logic [7:0] A_ACTIVE_PPR = 8'h20;
    localparam logic [7:0] A_POS_CNT = 8'h24;

    // ==================== Field positions
    localparam int CTRL_FULL_CLOSED = 0; // Full-closed control mode
    localparam int CTRL_POWER_ON = 1; // Write one: control power-on load
    localparam int ST_MULT_ERR = 0;
    localparam int ST_HYB_DEV = 1;
    localparam int ST_W = 2;

    // ==================== Types
    typedef struct packed {
        logic [31:0] num;
        logic [31:0] den;
    } ratio_t;

    typedef struct packed {
        logic step;
        logic dir;
    } pulse_t;

endpackage

// ### frac_scaler.sv
// Fractional pulse scaler: each input step taken while not busy adds num to an accumulator and
// emits whole output counts, carrying the remainder modulo den.
// Assumes num and den nonzero and at most one step per enabled cycle.
`timescale 1ns/1ps
`default_nettype none
module frac_scaler (
    input wire logic clock, // System clock
    input wire logic rst_b_sync, // Synchronised reset, active low
    input wire logic ce, // Clock enable
    input wire gear_pkg::ratio_t ratio, // Active ratio
    input wire gear_pkg::pulse_t pin, // Input step
    output logic busy, // Still emitting counts
    output logic overrun, // Step arrived while busy
    output gear_pkg::pulse_t pout // Output count step
);
    logic [31:0] acc_ff;
    logic [31:0] nxt_acc;
    logic dir_ff;
    logic nxt_dir;
    gear_pkg::pulse_t pout_ff;
    gear_pkg::pulse_t nxt_pout;

    // Remainder carried across steps, one count per cycle out
    always_comb begin
        nxt_acc = acc_ff;
        nxt_dir = dir_ff;
        nxt_pout = '0;
        if (pin.step && acc_ff < ratio.den) begin
            nxt_acc = acc_ff + ratio.num;
            nxt_dir = pin.dir;
        end else if (acc_ff >= ratio.den) begin
            nxt_acc = acc_ff - ratio.den;
            nxt_pout.step = 1'b1;
            nxt_pout.dir = dir_ff;
        end
    end

    // Accumulator and direction
    always_ff @(posedge clock or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            acc_ff <= '0;
            dir_ff <= 1'b0;
            pout_ff <= '0;
        end else if (ce) begin
            acc_ff <= nxt_acc;
            dir_ff <= nxt_dir;
            pout_ff <= nxt_pout;
        end
    end

    assign busy = acc_ff >= ratio.den;
    assign overrun = pin.step && busy;
    assign pout = pout_ff;
endmodule
`default_nettype wire

// ### gear_scaler_monitor.sv
// Checker for gear_scaler: bus answer timing, alarm causes, count causes.
// Assumes it is bound to gear_scaler and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gear_scaler_monitor (
    input wire logic clock, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic [31:0] wb_adr_i, // Address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic wb_we_i, // Write
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Acknowledge
    input wire gear_pkg::pulse_t cmd_in, // Command step
    input wire gear_pkg::pulse_t pos_cmd, // Scaled count
    input wire logic multiplication_error_alarm, // Sticky alarm
    input wire logic hybrid_deviation_alarm, // Sticky alarm
    input wire logic irq // Interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic wr_any;
    logic clr_mult;
    // ==================== Helpers
    // Write requests and status clears seen at the port
    assign wr_any = wb_cyc_i && wb_stb_i && wb_we_i;
    assign clr_mult = wr_any && wb_adr_i[7:0] == gear_pkg::A_STATUS && wb_dat_i[0];
    // ==================== Sequences
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ==================== Assertions
    a_ack_timing: assert property (s_take |=> s_answer)
        else $error("ack not one cycle after take");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (s_take ##0 (!wb_we_i && wb_adr_i[7:0] > 8'h24)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_irq_cause: assert property (irq |-> multiplication_error_alarm || hybrid_deviation_alarm)
        else $error("irq without alarm");
    a_mult_sticky: assert property ($fell(multiplication_error_alarm) |->
        $past(clr_mult) || $past(clr_mult, 2)) else $error("alarm dropped without clear");
    a_mult_cause: assert property ($rose(multiplication_error_alarm) |->
        $past(cmd_in.step) || $past(cmd_in.step, 2)) else $error("alarm without step");
    a_hyb_cause: assert property ($rose(hybrid_deviation_alarm) |->
        $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
        else $error("hybrid alarm without write");
    a_pos_cause: assert property ($rose(pos_cmd.step) |->
        $past(cmd_in.step) || $past(cmd_in.step, 2) || $past(cmd_in.step, 3))
        else $error("count without command step");
endmodule
bind gear_scaler gear_scaler_monitor gear_scaler_monitor_inst (
    .clock(clock), .rst_b(rst_b), .ce(ce), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmd_in(cmd_in), .pos_cmd(pos_cmd), .irq(irq),
    .multiplication_error_alarm(multiplication_error_alarm),
    .hybrid_deviation_alarm(hybrid_deviation_alarm));
`default_nettype wire

// ### cmd_host.sv
// Host model: sends a train of command steps with a chosen spacing.
// Assumes the bench starts a train with go only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
    input wire logic clock, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic go, // Start a train
    input wire logic [7:0] count, // Steps in the train
    input wire logic [7:0] gap, // Idle cycles between steps
    input wire logic dir, // Direction, 1 negative
    output gear_pkg::pulse_t cmd, // Step and direction
    output logic busy // Train in progress
);
    logic [7:0] left_ff;
    logic [7:0] wait_ff;
    logic dir_ff;
    // ==================== Train generator
    // Direction toggles while idle so no stale level is seen
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= '0;
            busy <= 1'b0;
            left_ff <= 8'h00;
            wait_ff <= 8'h00;
            dir_ff <= 1'b0;
        end else begin
            cmd.step <= 1'b0;
            if (go && !busy) begin
                left_ff <= count;
                wait_ff <= 8'h00;
                dir_ff <= dir;
                busy <= count != 8'h00;
            end else if (busy) begin
                if (wait_ff != 8'h00) begin
                    wait_ff <= wait_ff - 8'h01;
                end else begin
                    cmd.step <= 1'b1;
                    cmd.dir <= dir_ff;
                    left_ff <= left_ff - 8'h01;
                    wait_ff <= gap;
                    busy <= left_ff != 8'h01;
                end
            end else begin
                cmd.dir <= ~cmd.dir;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Bench for gear_scaler: register access, ratio modes, alarms, interrupt.
// Assumes cmd_host drives command steps and the bench drives the bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic go = 1'b0;
    logic dir = 1'b0;
    logic [7:0] gap = 8'h08;
    logic [7:0] npul = 8'h00;
    logic busy, ack, mult, hyb, irq;
    logic [31:0] dat_o;
    gear_pkg::pulse_t cmd, pos, enc_o;
    int enc_net = 0;
    int ebase;
    int err_total = 0;
    int n_checks = 0;
    int pos_net = 0;
    int base;
    // ==================== Clock and instances
    initial begin
        forever #50 clock = ~clock;
    end
    gear_scaler gear_scaler_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .cmd_in(cmd), .pos_cmd(pos), .enc_in(cmd),
        .enc_out(enc_o), .multiplication_error_alarm(mult), .hybrid_deviation_alarm(hyb),
        .irq(irq));
    cmd_host cmd_host_inst (.clock(clock), .rst_b(rst_b), .go(go), .count(npul), .gap(gap),
        .dir(dir), .cmd(cmd), .busy(busy));
    // Net signed count of scaled steps
    always @(posedge clock) begin
        if (pos.step === 1'b1)
            pos_net <= pos_net + (pos.dir ? -1 : 1);
        if (enc_o.step === 1'b1)
            enc_net <= enc_net + (enc_o.dir ? -1 : 1);
    end
    // ==================== Tasks
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        dat <= d;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task pulses(input logic [7:0] n, input logic d, input int e);
        int i;
        base = pos_net;
        ebase = enc_net;
        @(posedge clock);
        npul <= n;
        dir <= d;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while ((busy !== 1'b0 || pos_net - base != e) && i < 500);
        if (i >= 500) begin
            err_total++;
            wrap_up();
        end
        repeat (10) @(posedge clock);
        `CHK(pos_net - base, e)
    endtask
    // ==================== Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        rd(gear_pkg::A_PPR, gear_pkg::RST_PPR);
        rd(gear_pkg::A_NUM, gear_pkg::RST_NUM);
        rd(gear_pkg::A_DEN, gear_pkg::RST_DEN);
        rd(gear_pkg::A_OUT_PPR, gear_pkg::RST_OUT_PPR);
        rd(gear_pkg::A_OUT_DEN, gear_pkg::RST_OUT_DEN);
        rd(gear_pkg::A_ACTIVE_PPR, gear_pkg::RST_PPR);
        rd(8'h40, 32'h0);
        wr(gear_pkg::A_OUT_PPR, 32'hffff_ffff);
        rd(gear_pkg::A_OUT_PPR, gear_pkg::OUT_PPR_MAX);
        $display("test reset done");
        wr(gear_pkg::A_NUM, 32'h3);
        wr(gear_pkg::A_PPR, gear_pkg::PPR_MAX);
        rd(gear_pkg::A_ACTIVE_PPR, gear_pkg::RST_PPR);
        wr(gear_pkg::A_CTRL, 32'h2);
        rd(gear_pkg::A_ACTIVE_PPR, gear_pkg::PPR_MAX);
        pulses(8'h05, 1'b0, 5);
        `CHK(enc_net, 5)
        rd(gear_pkg::A_POS_CNT, 32'h5);
        wr(gear_pkg::A_PPR, 32'h0);
        wr(gear_pkg::A_NUM, 32'h0);
        wr(gear_pkg::A_DEN, 32'h0040_0000);
        wr(gear_pkg::A_CTRL, 32'h2);
        pulses(8'h04, 1'b0, 8);
        wr(gear_pkg::A_NUM, 32'h3);
        wr(gear_pkg::A_DEN, 32'h2);
        wr(gear_pkg::A_OUT_PPR, 32'h3);
        wr(gear_pkg::A_OUT_DEN, 32'h2);
        wr(gear_pkg::A_CTRL, 32'h2);
        pulses(8'h04, 1'b1, -6);
        `CHK(enc_net - ebase, -6)
        `CHK(mult, 1'b0)
        $display("test position done");
        wr(gear_pkg::A_NUM, 32'h0);
        wr(gear_pkg::A_PPR, 32'h10);
        wr(gear_pkg::A_CTRL, 32'h3);
        pulses(8'h03, 1'b0, 3);
        `CHK(hyb, 1'b0)
        wr(gear_pkg::A_NUM, 32'h3);
        rd(gear_pkg::A_STATUS, 32'h2);
        pulses(8'h02, 1'b0, 3);
        `CHK(irq, 1'b0)
        wr(gear_pkg::A_MASK, 32'h3);
        rd(gear_pkg::A_MASK, 32'h3);
        `CHK(irq, 1'b1)
        wr(gear_pkg::A_STATUS, 32'h2);
        rd(gear_pkg::A_STATUS, 32'h0);
        `CHK(irq, 1'b0)
        $display("test closed done");
        wr(gear_pkg::A_PPR, 32'h0);
        wr(gear_pkg::A_CTRL, 32'h2);
        wr(gear_pkg::A_DEN, 32'h1);
        gap <= 8'h00;
        pulses(8'h02, 1'b0, 3);
        gap <= 8'h08;
        rd(gear_pkg::A_STATUS, 32'h1);
        `CHK(irq, 1'b1)
        wr(gear_pkg::A_STATUS, 32'h1);
        rd(gear_pkg::A_STATUS, 32'h0);
        $display("test overrun done");
        wrap_up();
    end
endmodule
`default_nettype wire
